// ---- logic/mlrw_pkg.sv ----
package mlrw_pkg;

  // clock rate and switch debounce time
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned DEBOUNCE_MS     = 16;
  // divides exactly to 2000000 cycles; well above 4096 cycles, so the top exposes it as a parameter
  localparam int unsigned DEBOUNCE_CYC    = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int unsigned DEBOUNCE_W      = 32;

  // modem status register field positions
  localparam int unsigned MSR_TRAILING_EDGE_CALL_FLAG_BIT    = 2;
  localparam int unsigned MSR_RING_BIT    = 6;
  // modem control register field positions
  localparam int unsigned MCR_RTS_BIT     = 1;
  localparam int unsigned MCR_LOOP_BIT    = 4;

  // reset values
  localparam logic [7:0]  MSR_RST         = 8'h00;
  localparam logic        RTS_N_RST       = 1'b1;

  // power-off request output style
  typedef enum logic {
    MLRW_POFF_PULSE,
    MLRW_POFF_LEVEL
  } mlrw_poff_mode_e;

  // ring-wake pin choice
  typedef enum logic {
    MLRW_RING_PIN_A,
    MLRW_RING_PIN_B
  } mlrw_ring_pin_e;

endpackage : mlrw_pkg

// ---- logic/mlrw_debounce.sv ----
`timescale 1ns/1ps

// holds a new input level only once it has stayed stable for the full count
module mlrw_debounce
  import mlrw_pkg::*;
#(
  parameter int unsigned COUNT = DEBOUNCE_CYC
) (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  // raw and filtered level
  input  wire logic raw_i,
  output logic      level_o
);

  typedef struct packed {
    logic                  level;  // accepted level
    logic [DEBOUNCE_W-1:0] cnt;    // stability counter
  } mlrw_db_s;

  mlrw_db_s st_r;
  mlrw_db_s st_nxt;

  // count while the input differs; any bounce restarts the wait
  always_comb begin
    st_nxt = st_r;
    if (raw_i == st_r.level) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt >= COUNT[DEBOUNCE_W-1:0] - 1'b1) begin
      st_nxt.level = raw_i;
      st_nxt.cnt   = '0;
    end else begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  // idle level is high, matching the pulled-up switch
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '{level: 1'b1, cnt: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_o = st_r.level;

endmodule : mlrw_debounce

// ---- logic/mlrw_top.sv ----
`timescale 1ns/1ps

module mlrw_top
  import mlrw_pkg::*;
#(
  parameter int unsigned DEBOUNCE_COUNT = DEBOUNCE_CYC
) (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  // modem pins, ring indicators active low
  input  wire logic       ring_ind_n_i,
  input  wire logic       ring_ind2_n_i,
  output logic            rts_n_o,
  // modem registers, flattened to ports
  input  wire logic       msr_rd_i,
  output logic [7:0]      msr_data_o,
  input  wire logic       mcr_wr_i,
  input  wire logic [7:0] mcr_wdata_i,
  input  wire logic       msr_int_en_i,
  output logic            irq_o,
  // power manager configuration
  input  wire logic       ring_wake_en_i,
  input  wire logic       wake_pin_sel_i,
  input  wire logic       poff_level_mode_i,
  input  wire logic       poff_ack_i,
  // power manager pins
  input  wire logic       wake_a_n_i,
  input  wire logic       wake_b_n_i,
  input  wire logic       switch_n_i,
  input  wire logic       core_power_i,
  output logic            power_on_req_o,
  output logic            power_on_req_oe_o,
  output logic            power_off_req_o
);

  typedef struct packed {
    logic       ring_d;     // previous ring level, channel 1
    logic       ring2_d;    // previous ring level, channel 2
    logic       wake_d;     // previous selected wake level
    logic       sw_d;       // previous debounced switch level
    logic       trailing_edge_call_flag;       // trailing-edge call flag
    logic       rts_bit;    // control bit for request-to-send
    logic       loop_bit;   // loopback select
    logic [7:0] msr_data;   // read data latch
    logic       rts_n;      // request-to-send pin
    logic       irq;        // modem status interrupt
    logic       on_req;     // power-on request held active
    logic       off_req;    // power-off request output
  } mlrw_st_s;

  mlrw_st_s st_r;
  mlrw_st_s st_nxt;

  logic sw_level;       // debounced switch
  logic wake_sel;       // wake input chosen by configuration
  logic ring_rise;      // channel 1 leaving ring state
  logic ring_fall;      // either channel entering ring state
  logic wake_fall;      // start of an active-low wake pulse
  logic sw_off_evt;     // accepted switch-off event

  // switch filter; inputs are synchronous so no extra stages here
  mlrw_debounce #(
    .COUNT (DEBOUNCE_COUNT)
  ) u_switch_db (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .raw_i     (switch_n_i),
    .level_o   (sw_level)
  );

  // edge detection on the live pin levels and the debounced switch level
  always_comb begin
    wake_sel   = (wake_pin_sel_i == MLRW_RING_PIN_B) ? wake_b_n_i : wake_a_n_i;
    ring_rise  = ring_ind_n_i & ~st_r.ring_d;
    ring_fall  = (~ring_ind_n_i & st_r.ring_d) | (~ring_ind2_n_i & st_r.ring2_d);
    wake_fall  = ~wake_sel & st_r.wake_d;
    sw_off_evt = ~sw_level & st_r.sw_d & core_power_i;
  end

  // next state for registers, pins and power requests
  always_comb begin
    st_nxt         = st_r;
    st_nxt.ring_d  = ring_ind_n_i;
    st_nxt.ring2_d = ring_ind2_n_i;
    st_nxt.wake_d  = wake_sel;
    st_nxt.sw_d    = sw_level;

    // read snapshots current status, then clears the flag
    if (msr_rd_i) begin
      st_nxt.msr_data                = MSR_RST;
      st_nxt.msr_data[MSR_RING_BIT]  = ~ring_ind_n_i;
      st_nxt.msr_data[MSR_TRAILING_EDGE_CALL_FLAG_BIT]  = st_r.trailing_edge_call_flag | ring_rise;
      st_nxt.trailing_edge_call_flag                    = 1'b0;
    end
    // a new edge in the read cycle wins over the clear
    if (ring_rise) begin
      st_nxt.trailing_edge_call_flag = 1'b1;
    end
    st_nxt.irq = st_nxt.trailing_edge_call_flag & msr_int_en_i;

    // control register write
    if (mcr_wr_i) begin
      st_nxt.rts_bit  = mcr_wdata_i[MCR_RTS_BIT];
      st_nxt.loop_bit = mcr_wdata_i[MCR_LOOP_BIT];
    end
    // loopback forces the pin inactive regardless of the bit
    st_nxt.rts_n = ~(st_nxt.rts_bit & ~st_nxt.loop_bit);

    // power-on request holds until main power arrives
    if ((ring_wake_en_i & ring_fall) | wake_fall) begin
      st_nxt.on_req = 1'b1;
    end else if (core_power_i) begin
      st_nxt.on_req = 1'b0;
    end

    // power-off request: one cycle pulse or level until acknowledged
    if (sw_off_evt) begin
      st_nxt.off_req = 1'b1;
    end else if (poff_level_mode_i == MLRW_POFF_LEVEL) begin
      if (poff_ack_i) begin
        st_nxt.off_req = 1'b0;
      end
    end else begin
      st_nxt.off_req = 1'b0;
    end
  end

  // single state register; reset leaves request-to-send inactive
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '{ring_d: 1'b1, ring2_d: 1'b1, wake_d: 1'b1, sw_d: 1'b1,
                trailing_edge_call_flag: 1'b0, rts_bit: 1'b0, loop_bit: 1'b0, msr_data: MSR_RST,
                rts_n: RTS_N_RST, irq: 1'b0, on_req: 1'b0, off_req: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // open-drain: pin driven low only while requesting
  assign power_on_req_o    = 1'b0;
  assign power_on_req_oe_o = st_r.on_req;
  assign rts_n_o           = st_r.rts_n;
  assign msr_data_o        = st_r.msr_data;
  assign irq_o             = st_r.irq;
  assign power_off_req_o   = st_r.off_req;

endmodule : mlrw_top

// ---- test/mlrw_monitor.sv ----
`timescale 1ns/1ps
// watches the top ports; every bound is in clock cycles
module mlrw_monitor #(parameter int unsigned DEBOUNCE_COUNT = 8) (
  input wire logic       clk_sys_i, rst_i, ring_ind_n_i, ring_ind2_n_i, rts_n_o,
  input wire logic       msr_rd_i, mcr_wr_i, msr_int_en_i, irq_o, ring_wake_en_i,
  input wire logic       wake_pin_sel_i, wake_a_n_i, poff_level_mode_i, poff_ack_i,
  input wire logic       power_off_req_o, power_on_req_oe_o,
  input wire logic [7:0] msr_data_o, mcr_wdata_i
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // ring release, interrupts on, and no read to clear the flag meanwhile
  sequence ring_rose_s;
    $rose(ring_ind_n_i) && msr_int_en_i && !msr_rd_i ##1 (msr_int_en_i && !msr_rd_i) [*2];
  endsequence
  ring_bit_a: assert property (msr_rd_i |=> msr_data_o[6] == !$past(ring_ind_n_i))
    else $error("ring bit");
  flag_irq_a: assert property (ring_rose_s |-> ##[0:1] irq_o)
    else $error("no irq");
  rts_drive_a: assert property (mcr_wr_i && !mcr_wdata_i[4]
    |=> rts_n_o != $past(mcr_wdata_i[1])) else $error("rts level");
  loop_hold_a: assert property (mcr_wr_i && mcr_wdata_i[4] |=> rts_n_o)
    else $error("rts in loopback");
  ring_wake_a: assert property (ring_wake_en_i && $fell(ring_ind2_n_i)
    |=> power_on_req_oe_o) else $error("ring wake");
  pin_wake_a: assert property (!wake_pin_sel_i && $fell(wake_a_n_i)
    |=> power_on_req_oe_o) else $error("pin wake");
  poff_pulse_a: assert property ($rose(power_off_req_o) && !poff_level_mode_i
    |=> !power_off_req_o) else $error("pulse too long");
  poff_level_a: assert property (power_off_req_o && poff_level_mode_i && !poff_ack_i
    |=> power_off_req_o) else $error("level dropped");
endmodule : mlrw_monitor

bind mlrw_top mlrw_monitor #(.DEBOUNCE_COUNT(DEBOUNCE_COUNT)) u_mon (.*);

// ---- test/mlrw_supply_model.sv ----
`timescale 1ns/1ps
// main supply: comes up a few cycles after the pull-down, drops on power-off
module mlrw_supply_model (
  input wire logic clk_sys_i, rst_i, on_oe_i, off_i,
  output logic     core_power_o
);
  logic [2:0] wait_r; // cycles the pull-down has been seen
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      core_power_o <= 1'b0;
      wait_r       <= 3'h0;
    end else if (off_i) begin
      core_power_o <= 1'b0;
      wait_r       <= 3'h0;
    end else if (on_oe_i) begin
      wait_r       <= wait_r + 3'h1;
      core_power_o <= core_power_o | (wait_r == 3'h4);
    end
  end
endmodule : mlrw_supply_model

// ---- test/test_modem_line_and_ring_wake.sv ----
`timescale 1ns/1ps
module test_modem_line_and_ring_wake;
  logic       clk_sys_i, rst_i, ring_ind_n_i, ring_ind2_n_i, msr_rd_i, mcr_wr_i;
  logic       msr_int_en_i, ring_wake_en_i, wake_pin_sel_i, poff_level_mode_i;
  logic       poff_ack_i, wake_a_n_i, wake_b_n_i, switch_n_i, core_power_i, rts_n_o;
  logic       irq_o, power_on_req_o, power_on_req_oe_o, power_off_req_o;
  logic [7:0] mcr_wdata_i, msr_data_o;
  // control byte, then expected request-to-send level
  logic [8:0] rows [5] = '{9'h004, 9'h001, 9'h025, 9'h1fb, 9'h01e};
  int         error_cnt = 0, checks = 0, i;
  // short debounce so a press settles in a few cycles
  mlrw_top #(.DEBOUNCE_COUNT(8)) DUT (.*);
  mlrw_supply_model u_sup (.clk_sys_i, .rst_i, .on_oe_i(power_on_req_oe_o),
    .off_i(power_off_req_o), .core_power_o(core_power_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk1(string n, logic e, logic s);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %b got %b", n, e, s);
    end
  endtask : chk1
  task automatic chk8(string n, logic [7:0] e, logic [7:0] s);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk8
  task automatic tk(int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : tk
  // bounded wait for a level, sampled just after each edge
  task automatic wt(ref logic s, input logic v);
    for (int n = 0; s !== v; n++) begin
      if (n == 200) begin
        error_cnt++;
        summarize();
      end
      tk(1);
      #1;
    end
    chk1("wait", v, s);
  endtask : wt
  task automatic rd();
    tk(1);
    msr_rd_i <= 1'b1;
    tk(1);
    msr_rd_i <= 1'b0;
    tk(2);
    #1;
  endtask : rd
  task automatic summarize();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  initial begin
    {msr_rd_i, mcr_wr_i, mcr_wdata_i, ring_wake_en_i, wake_pin_sel_i} = '0;
    {poff_level_mode_i, poff_ack_i, msr_int_en_i} = '0;
    {ring_ind_n_i, ring_ind2_n_i, wake_a_n_i, wake_b_n_i, switch_n_i} = '1;
    rst_i = 1'b1;
    tk(5);
    rst_i <= 1'b0;
    foreach (rows[k]) begin
      tk(1);
      mcr_wr_i    <= 1'b1;
      mcr_wdata_i <= rows[k][8:1];
      tk(1);
      mcr_wr_i    <= 1'b0;
      tk(2);
      #1 chk1("rts_n", rows[k][0], rts_n_o);
    end
    // reset in mid-run while the line is active
    tk(1);
    rst_i <= 1'b1;
    tk(2);
    #1 chk1("rts_rst", 1'b1, rts_n_o);
    tk(1);
    rst_i        <= 1'b0;
    msr_int_en_i <= 1'b1;
    ring_ind_n_i <= 1'b0;
    tk(3);
    ring_ind_n_i <= 1'b1;
    wt(irq_o, 1'b1);
    rd();
    chk8("msr", 8'h04, msr_data_o);
    chk1("irq", 1'b0, irq_o);
    rd();
    chk8("msr", 8'h00, msr_data_o);
    tk(1);
    ring_ind_n_i <= 1'b0;
    rd();
    chk8("msr_ring", 8'h40, msr_data_o);
    // wake by ring 2, pin a, pin b; each powered up, then switched off
    for (i = 0; i < 3; i++) begin
      tk(1);
      ring_wake_en_i    <= 1'b1;
      wake_pin_sel_i    <= (i == 2);
      poff_level_mode_i <= (i == 1);
      tk(1);
      ring_ind2_n_i <= (i != 0);
      wake_a_n_i    <= (i != 1);
      wake_b_n_i    <= (i != 2);
      tk(2);
      {ring_ind2_n_i, wake_a_n_i, wake_b_n_i} <= 3'h7;
      wt(power_on_req_oe_o, 1'b1);
      chk1("pon", 1'b0, power_on_req_o);
      wt(power_on_req_oe_o, 1'b0);
      tk(1);
      switch_n_i <= 1'b0;
      wt(power_off_req_o, 1'b1);
      tk(3);
      #1 chk1("poff", i == 1, power_off_req_o);
      tk(1);
      poff_ack_i <= 1'b1;
      switch_n_i <= 1'b1;
      tk(1);
      poff_ack_i <= 1'b0;
      tk(12);
      #1 chk1("poff_clr", 1'b0, power_off_req_o);
    end
    // a press while core power is absent must never request power off
    tk(1);
    switch_n_i <= 1'b0;
    for (i = 0; i < 14; i++) begin
      tk(1);
      #1 chk1("poff_nopwr", 1'b0, power_off_req_o);
    end
    summarize();
  end
endmodule : test_modem_line_and_ring_wake
